// ### bench/fpt_fan_model.sv
// Partner model: four three-pin fans with open-collector tach
// Assumes fan_sw_on powers each fan; tach is pulled up when unpowered
module fpt_fan_model #(
  parameter int unsigned HALF = 5
) (
  input  wire logic       aclk,
  input  wire logic [3:0] power_on,
  output logic      [3:0] tach = 4'hF
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4];  // Half-period counters
  // Spinning fan toggles tach; a stopped fan shows the pull-up level
  always @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!power_on[i]) begin
        tach[i] <= 1'b1;
        cnt[i]  <= 0;
      end else if (cnt[i] == HALF - 1) begin
        tach[i] <= ~tach[i];
        cnt[i]  <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// ### bench/test_fan_pwm_tach_monitor.sv
// Self-checking bench of the fan PWM and tachometer block
// Assumes short timing parameters; fans toggle tach every 5 cycles
module test_fan_pwm_tach_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import fpt_pkg::*;
  localparam int WIN = 200;  // Window length in cycles
  localparam int STG = 20;   // Start stagger in cycles
  logic                aclk = 1'b0;
  logic                aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready, boot_valid;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata, v;
  logic [3:0]          wstrb, tach_in, fan_sw_on;
  logic [1:0]          bresp, rresp, r;
  fpt_power_type [3:0] boot_power;
  int                  bad_count, check_count, cyc, tot, lng, t_up [4];

  fpt_top #(.PWM_SLICE_CYC(4), .WIN_CYC(WIN), .STAGGER_CYC(STG), .TICK_CYC(3)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .boot_valid, .boot_power, .tach_in, .fan_sw_on);
  fpt_fan_model #(.HALF(5)) fans (.aclk, .power_on(fan_sw_on), .tach(tach_in));

  always #5 aclk = ~aclk;
  // Cycle count, hang guard and first switch-on time per channel
  always @(negedge aclk) begin
    cyc++;
    for (int i = 0; i < 4; i++) begin
      if (aresetn && fan_sw_on[i] === 1'b1 && t_up[i] == 0) t_up[i] = cyc;
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(string n, logic [31:0] lo, logic [31:0] hi, logic [31:0] s);
    check_count++;
    if ($isunknown(s) || s < lo || s > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, s);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] rs);
    logic ag, wg, bg;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge aclk);
      {ag, wg, bg} = {awvalid & awready, wvalid & wready, bready & bvalid};
      if (bg) rs = bresp;
      @(posedge aclk);
      if (ag) awvalid <= 1'b0;
      if (wg) wvalid <= 1'b0;
      if (bg) bready <= 1'b0;
    end while (awvalid | wvalid | bready);
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ag, rg;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {ag, rg} = {arvalid & arready, rready & rvalid};
      if (rg) {d, rs} = {rdata, rresp};
      @(posedge aclk);
      if (ag) arvalid <= 1'b0;
      if (rg) rready <= 1'b0;
    end while (arvalid | rready);
  endtask
  // Total on-cycles and longest on-run of one switch
  task automatic run(int ch, int n);
    int cur = 0;
    {tot, lng} = 0;
    repeat (n) begin
      @(negedge aclk);
      cur = (fan_sw_on[ch] === 1'b1) ? cur + 1 : 0;
      tot += cur > 0;
      if (cur > lng) lng = cur;
    end
  endtask

  task automatic t_boot();
    rd(8'h10, v, r);
    chk("power0", 32'h10A64, 32'h10A64, v);
    rd(8'h1C, v, r);
    chk("power3", 32'h10A2D, 32'h10A2D, v);
    for (int i = 1; i < 4; i++) chk("stagger", t_up[i-1] + STG, 20000, t_up[i]);
  endtask
  task automatic t_regs();
    rd(8'h00, v, r);
    chk("ctrl", 0, 0, v);
    rd(8'h08, v, r);
    chk("win", WIN, WIN, v);
    wr(8'h04, 32'h1, r);
    chk("ro_resp", 2, 2, r);
    rd(8'hFC, v, r);
    chk("bad_resp", 2, 2, r);
    chk("bad_data", 0, 0, v);
  endtask
  // Duty over one whole period is power times four cycles
  task automatic t_duty();
    int p [4] = '{0, 1, 50, 100};
    foreach (p[i]) begin
      wr(8'h1C, 32'h10A00 | p[i], r);
      repeat (400) @(posedge aclk);
      run(3, 400);
      chk("duty", p[i] * 4, p[i] * 4, tot);
    end
  endtask
  task automatic t_speed();
    wr(8'h18, 32'h10064, r);
    repeat (900) @(posedge aclk);
    rd(8'h28, v, r);
    chk("raw2", 19, 21, v);
    rd(8'h20, v, r);
    chk("raw0", 19, 21, v);
    wr(8'h00, 32'h10, r);
    repeat (900) @(posedge aclk);
    rd(8'h28, v, r);
    chk("rpm2", 19 * 240, 21 * 240, v);
  endtask
  task automatic t_stretch();
    wr(8'h14, 32'h10A01, r);
    wr(8'h00, 32'h3, r);
    run(1, 1000);
    chk("stretch", 20, WIN, lng);
    run(0, 1000);
    chk("full", 1000, 1000, tot);
    wr(8'h00, 32'h0, r);
    run(1, 1000);
    chk("no_stretch", 0, 4, lng);
  endtask
  // Mid-run reset with no saved state: every power falls back to full
  task automatic t_reboot();
    @(posedge aclk);
    boot_valid <= 1'b0;
    aresetn    <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("rst_off", 0, 0, fan_sw_on);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(8'h1C, v, r);
    chk("default3", 32'h10A64, 32'h10A64, v);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    boot_valid = 1'b1;
    boot_power = {7'h2D, 7'h64, 7'h64, 7'h7F};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (600) @(posedge aclk);
    t_boot();
    t_regs();
    t_duty();
    t_speed();
    t_stretch();
    t_reboot();
    report_and_stop();
  end
endmodule

// ### hw/fpt_chan.sv
// One fan channel: tach synchroniser, glitch mask, stretch, edge count
// Assumes window strobes and tick come from the core on the same clock
`include "fpt_params.svh"
module fpt_chan (
  input wire logic   aclk,
  input wire logic   aresetn,
  input wire logic   tach_in,
  fpt_chan_if.chan   cif
);
  import fpt_pkg::*;
  logic           s1_q, s2_q, s3_q;   // Sync chain and edge history
  logic           sw_q;               // Switch state
  logic           force_q;            // Stretch in progress
  logic [1:0]     fedge_q;            // Edges seen while stretched
  fpt_glitch_type glt_q;              // Ticks since power applied
  fpt_count_type  run_q;              // Edges in current window
  fpt_count_type  edges_q;            // Edges of last window
  logic           glitch_done;
  logic           good_edge;

  // Two flops to synchronise, third only for edge detect
  // Reset to the idle pull-up level, so no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= tach_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign glitch_done = (glt_q >= cif.glitch);
  // Edges right after power-on are motor noise, not speed
  assign good_edge = s2_q & ~s3_q & sw_q & glitch_done;

  // Glitch timer restarts whenever power is removed
  always_ff @(posedge aclk) begin
    if (!aresetn || !sw_q) begin
      glt_q <= 8'h00;
    end else if (cif.tick && !glitch_done) begin
      glt_q <= glt_q + 8'h01;
    end
  end

  // Stretch: forced on at window start, released after two edges
  always_ff @(posedge aclk) begin
    if (!aresetn || cif.win_end) begin
      force_q <= 1'b0;
    end else if (cif.win_start && cif.report_en && cif.started) begin
      force_q <= 1'b1;
    end else if (force_q && glitch_done && fedge_q == 2'd2) begin
      force_q <= 1'b0;
    end
  end

  // Saturating count of edges while stretched
  always_ff @(posedge aclk) begin
    if (!aresetn || cif.win_start) begin
      fedge_q <= 2'd0;
    end else if (force_q && good_edge && fedge_q != 2'd2) begin
      fedge_q <= fedge_q + 2'd1;
    end
  end

  // Stretch only adds on-time, so full power is never disturbed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q <= 1'b0;
    end else begin
      sw_q <= cif.started & (cif.pwm_on | force_q);
    end
  end

  // Window edge count, held for software at window end
  always_ff @(posedge aclk) begin
    if (!aresetn || cif.win_start) begin
      run_q <= 16'h0000;
    end else if (good_edge && run_q != 16'hFFFF) begin
      run_q <= run_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edges_q <= 16'h0000;
    end else if (cif.win_end) begin
      edges_q <= run_q;
    end
  end

  assign cif.switch_on = sw_q;
  assign cif.force_on  = force_q;
  assign cif.edges     = edges_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_force_arm;
    cif.win_start && cif.report_en && cif.started;
  endsequence
  sequence s_forced_on;
    force_q ##1 sw_q;
  endsequence
  AST_FORCE_ON: assert property (s_force_arm |=> s_forced_on)
    else $error("switch not forced on at window start");
  AST_FORCE_HOLD: assert property ($fell(force_q) |->
    $past(cif.win_end) || $past(glitch_done && fedge_q == 2'd2))
    else $error("stretch ended early");
  AST_GLITCH_MASK: assert property ((!glitch_done && !cif.win_start)
    |=> $stable(run_q))
    else $error("edge counted inside glitch delay");
  AST_EDGES_LATCH: assert property (cif.win_end |=> edges_q == $past(run_q))
    else $error("window edge count not latched");
endmodule

// ### hw/fpt_chan_if.sv
// Signals between the block's control core and one fan channel
// Assumes the package is compiled first
interface fpt_chan_if;
  import fpt_pkg::*;
  logic           pwm_on;     // Normal PWM level
  logic           started;    // Channel released at power-up
  logic           win_start;  // Own window begins
  logic           win_end;    // Own window ends
  logic           report_en;  // Speed reporting wanted
  logic           tick;       // Glitch timebase pulse
  fpt_glitch_type glitch;     // Glitch delay in ticks
  logic           switch_on;  // Power switch state
  logic           force_on;   // Stretch active
  fpt_count_type  edges;      // Edges of last window
  modport ctl  (output pwm_on, started, win_start, win_end, report_en, tick, glitch,
                input switch_on, force_on, edges);
  modport chan (input pwm_on, started, win_start, win_end, report_en, tick, glitch,
                output switch_on, force_on, edges);
endinterface

// ### hw/fpt_params.svh
// Constants of the fan PWM and tachometer block
// Definitions only; included by the fpt_chan, fpt_stagger and fpt_top design files
`ifndef FPT_PARAMS_SVH
`define FPT_PARAMS_SVH
// Timing figures in their own units
`define FPT_CLK_HZ        100000000
`define FPT_PWM_HZ        18
`define FPT_PWM_STEPS     100
`define FPT_WIN_MS        125
`define FPT_STAGGER_MS    500
`define FPT_TICK_US       100
// Register byte offsets
`define FPT_CTRL_OFS      8'h00
`define FPT_STAT_OFS      8'h04
`define FPT_WIN_OFS       8'h08
`define FPT_POWER_OFS     8'h10
`define FPT_SPEED_OFS     8'h20
// Field positions
`define FPT_CTRL_REP_LSB  0
`define FPT_CTRL_RPM_BIT  4
`define FPT_PWR_LSB       0
`define FPT_GLT_LSB       8
`define FPT_PPR_LSB       16
// Reset values
`define FPT_REP_RST       4'h0
`define FPT_POWER_FULL    7'h64
`define FPT_GLT_RST       8'h0A
`define FPT_PPR_RST       2'h1
`endif

// ### hw/fpt_pkg.sv
// Types shared by the fan PWM and tachometer block
// Assumes nothing beyond a SystemVerilog compiler
package fpt_pkg;
  typedef logic [6:0]  fpt_power_type;   // Percent, 0 to 100
  typedef logic [7:0]  fpt_glitch_type;  // Glitch delay in ticks
  typedef logic [1:0]  fpt_ppr_type;     // Log2 of pulses per rev
  typedef logic [15:0] fpt_count_type;   // Edge count
  typedef logic [1:0]  fpt_ch_type;      // Channel index
  typedef enum logic [1:0] {
    FPT_RESP_OKAY   = 2'b00,
    FPT_RESP_SLVERR = 2'b10
  } fpt_resp_type;
  typedef enum logic [1:0] {
    FPT_SEQ_STEP = 2'b00,
    FPT_SEQ_WAIT = 2'b01,
    FPT_SEQ_DONE = 2'b10
  } fpt_seq_type;
endpackage

// ### hw/fpt_stagger.sv
// Power-up sequencer: releases fans one by one
// Assumes go rises once the boot power settings are loaded
`include "fpt_params.svh"
module fpt_stagger #(
  parameter int unsigned STAGGER_CYC = 50000000
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [3:0] on_mask,
  output logic      [3:0] started
);
  import fpt_pkg::*;
  fpt_seq_type st_q;   // Sequencer state
  fpt_ch_type  idx_q;  // Channel being released
  logic [31:0] gap_q;  // Cycles left before next release

  // A fan that stays off costs no current, so no wait after it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= FPT_SEQ_STEP;
      idx_q   <= 2'd0;
      gap_q   <= 32'h0;
      started <= 4'h0;
    end else begin
      unique case (st_q)
        FPT_SEQ_STEP: if (go) begin
          started[idx_q] <= 1'b1;
          if (on_mask[idx_q]) begin
            gap_q <= 32'(STAGGER_CYC - 1);
            st_q  <= FPT_SEQ_WAIT;
          end else if (idx_q == 2'd3) begin
            st_q <= FPT_SEQ_DONE;
          end else begin
            idx_q <= idx_q + 2'd1;
          end
        end
        FPT_SEQ_WAIT: if (gap_q == 32'h0) begin
          if (idx_q == 2'd3) begin
            st_q <= FPT_SEQ_DONE;
          end else begin
            idx_q <= idx_q + 2'd1;
            st_q  <= FPT_SEQ_STEP;
          end
        end else begin
          gap_q <= gap_q - 32'h1;
        end
        FPT_SEQ_DONE: st_q <= FPT_SEQ_DONE;
        default:      st_q <= FPT_SEQ_DONE;
      endcase
    end
  end
endmodule

// ### hw/fpt_top.sv
// Four-channel fan PWM and tachometer monitor with AXI4-Lite registers
// Assumes one 100 MHz clock; tach inputs are asynchronous to it
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`include "fpt_params.svh"

// Functional notes
// - Four independent fan channels
// - Power percent sets low-side switch duty
// - PWM period is 18 Hz
// - Tach averaged over 1/8 second window
// - Channels measured round-robin, 125 ms each
// - Reporting fan forced on at window start
// - Stay on until glitch delay, two edges
// - Stretched pulse lasts at most 1/8 second
// - Report RPM or raw count per channel; one rpm_mode_q bit sets the mode for all channels
// - Full-power on-time left unaltered; shorter on-times may be stretched
// - Boot power loaded; fans started 0.5 s apart; a fan at zero power gets no gap after it
module fpt_top #(
  parameter int unsigned PWM_SLICE_CYC = `FPT_CLK_HZ / (`FPT_PWM_HZ * `FPT_PWM_STEPS),
  parameter int unsigned WIN_CYC       = `FPT_CLK_HZ / 1000 * `FPT_WIN_MS,
  parameter int unsigned STAGGER_CYC   = `FPT_CLK_HZ / 1000 * `FPT_STAGGER_MS,
  parameter int unsigned TICK_CYC      = `FPT_CLK_HZ / 1000000 * `FPT_TICK_US
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [7:0]                    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [7:0]                    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic                          boot_valid,
  input  wire fpt_pkg::fpt_power_type [3:0]  boot_power,
  input  wire logic [3:0]                    tach_in,
  output logic [3:0]                         fan_sw_on
);
  import fpt_pkg::*;

  // Scale from pulses per window to pulses per minute
  localparam logic [31:0] RPM_SCALE = 32'(60 * 1000 / `FPT_WIN_MS);
  localparam logic [6:0]  LAST_STEP = 7'(`FPT_PWM_STEPS - 1);

  // Software settings
  logic [3:0]     report_q;         // Per-channel reporting enable
  logic           rpm_mode_q;       // Speed reads RPM, else raw
  fpt_power_type  power_q  [4];     // Power percent
  fpt_glitch_type glitch_q [4];     // Glitch delay
  fpt_ppr_type    ppr_q    [4];     // Pulses per rev, log2
  logic           boot_done_q;      // Boot settings taken

  // Bus slave state
  logic           aw_hold_q;        // Write address held
  logic [7:0]     aw_addr_q;
  logic           w_hold_q;         // Write data held
  logic [31:0]    w_data_q;
  logic [3:0]     w_strb_q;
  logic           bvalid_q;
  fpt_resp_type   bresp_q;
  logic           rvalid_q;
  logic [31:0]    rdata_q;
  fpt_resp_type   rresp_q;
  logic           do_wr;            // Write performed this cycle
  logic           wr_hit;           // Write address mapped
  logic [31:0]    rd_word;          // Read mux output
  logic           rd_hit;           // Read address mapped
  logic [31:0]    ctrl_new;         // Control word after write merge
  logic [31:0]    pwr_new;          // Power word after write merge

  // Timebases
  logic [31:0]    slice_q;          // Cycles within PWM step
  logic [6:0]     step_q;           // PWM step 0..99
  logic [31:0]    tick_q;           // Glitch tick divider
  logic           tick;
  logic [31:0]    win_q;            // Cycles within window
  fpt_ch_type     cur_ch_q;         // Channel being measured
  logic           win_last;

  // Channel views
  logic [3:0]     started;
  logic [3:0]     pwm_on;
  logic [3:0]     on_mask;
  logic [3:0]     force_vec;
  fpt_count_type  edges [4];

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Settings above full power mean full power
  function automatic fpt_power_type clamp(input logic [6:0] p);
    return (p > `FPT_POWER_FULL) ? `FPT_POWER_FULL : p;
  endfunction

  // True when an address falls in the power or speed register bank
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return a[7:4] == base[7:4];
  endfunction

  // Speed from a window count: pulses times 480 over pulses per rev
  function automatic logic [31:0] rpm(input fpt_count_type n, input fpt_ppr_type p);
    logic [31:0] prod;
    prod = 32'(n) * RPM_SCALE;
    return prod >> p;
  endfunction

  // Power register image
  function automatic logic [31:0] power_word(input int i);
    logic [31:0] w;
    w = 32'h0;
    w[`FPT_PWR_LSB +: 7] = power_q[i];
    w[`FPT_GLT_LSB +: 8] = glitch_q[i];
    w[`FPT_PPR_LSB +: 2] = ppr_q[i];
    return w;
  endfunction

  // Write channel: each of address and data is held until both are in
  assign awready = !aw_hold_q;
  assign wready  = !w_hold_q;
  assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_hit  = (aw_addr_q == `FPT_CTRL_OFS) || in_bank(aw_addr_q, `FPT_POWER_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_wr) begin
      w_hold_q <= 1'b0;
    end
  end

  // Write response; unmapped or read-only targets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= FPT_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? FPT_RESP_OKAY : FPT_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // Merged write words; a process, so reads inside functions are tracked
  always_comb begin
    ctrl_new = merge({27'h0, rpm_mode_q, report_q}, w_data_q, w_strb_q);
    pwr_new  = merge(power_word(int'(aw_addr_q[3:2])), w_data_q, w_strb_q);
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      report_q   <= `FPT_REP_RST;
      rpm_mode_q <= 1'b0;
    end else if (do_wr && aw_addr_q == `FPT_CTRL_OFS) begin
      report_q   <= ctrl_new[`FPT_CTRL_REP_LSB +: 4];
      rpm_mode_q <= ctrl_new[`FPT_CTRL_RPM_BIT];
    end
  end

  // Per-channel power registers; boot values taken once after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_done_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        power_q[i]  <= `FPT_POWER_FULL;
        glitch_q[i] <= `FPT_GLT_RST;
        ppr_q[i]    <= `FPT_PPR_RST;
      end
    end else if (!boot_done_q) begin
      boot_done_q <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        power_q[i] <= boot_valid ? clamp(boot_power[i]) : `FPT_POWER_FULL;
      end
    end else if (do_wr && in_bank(aw_addr_q, `FPT_POWER_OFS)) begin
      power_q[aw_addr_q[3:2]]  <= clamp(pwr_new[`FPT_PWR_LSB +: 7]);
      glitch_q[aw_addr_q[3:2]] <= pwr_new[`FPT_GLT_LSB +: 8];
      ppr_q[aw_addr_q[3:2]]    <= pwr_new[`FPT_PPR_LSB +: 2];
    end
  end

  // Read mux over settings and live state
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    if (araddr == `FPT_CTRL_OFS) begin
      rd_word = {27'h0, rpm_mode_q, report_q};
    end else if (araddr == `FPT_STAT_OFS) begin
      rd_word = {18'h0, cur_ch_q, force_vec, fan_sw_on, started};
    end else if (araddr == `FPT_WIN_OFS) begin
      rd_word = WIN_CYC;
    end else if (in_bank(araddr, `FPT_POWER_OFS)) begin
      rd_word = power_word(int'(araddr[3:2]));
    end else if (in_bank(araddr, `FPT_SPEED_OFS)) begin
      // Raw count lets the host do its own arithmetic
      rd_word = rpm_mode_q ? rpm(edges[araddr[3:2]], ppr_q[araddr[3:2]])
                           : {16'h0, edges[araddr[3:2]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  assign arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= FPT_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? FPT_RESP_OKAY : FPT_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // PWM timebase: 100 steps make one period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slice_q <= 32'h0;
      step_q  <= 7'h00;
    end else if (slice_q == 32'(PWM_SLICE_CYC - 1)) begin
      slice_q <= 32'h0;
      step_q  <= (step_q == LAST_STEP) ? 7'h00 : step_q + 7'h01;
    end else begin
      slice_q <= slice_q + 32'h1;
    end
  end

  // Glitch timebase
  assign tick = (tick_q == 32'(TICK_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_q <= 32'h0;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // Measurement windows visit channels in turn
  assign win_last = (win_q == 32'(WIN_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_q    <= 32'h0;
      cur_ch_q <= 2'd0;
    end else if (win_last) begin
      win_q    <= 32'h0;
      cur_ch_q <= cur_ch_q + 2'd1;
    end else begin
      win_q <= win_q + 32'h1;
    end
  end

  // Power-up release of the fans
  fpt_stagger #(
    .STAGGER_CYC (STAGGER_CYC)
  ) u_stagger (
    .aclk    (aclk),
    .aresetn (aresetn),
    .go      (boot_done_q),
    .on_mask (on_mask),
    .started (started)
  );

  fpt_chan_if cif [4] ();

  // Four identical channels
  for (genvar i = 0; i < 4; i++) begin : g_ch
    assign pwm_on[i]  = step_q < power_q[i];
    assign on_mask[i] = power_q[i] != 7'h00;
    assign cif[i].pwm_on    = pwm_on[i];
    assign cif[i].started   = started[i];
    assign cif[i].win_start = (win_q == 32'h0) && (cur_ch_q == 2'(i));
    assign cif[i].win_end   = win_last && (cur_ch_q == 2'(i));
    assign cif[i].report_en = report_q[i];
    assign cif[i].tick      = tick;
    assign cif[i].glitch    = glitch_q[i];
    assign fan_sw_on[i]     = cif[i].switch_on;
    assign force_vec[i]     = cif[i].force_on;
    assign edges[i]         = cif[i].edges;

    fpt_chan u_chan (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tach_in (tach_in[i]),
      .cif     (cif[i])
    );
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ZERO_OFF: assert property ((started[3] && power_q[3] == 7'h00
    && !force_vec[3]) |=> !fan_sw_on[3])
    else $error("zero power channel switched on");
  AST_FULL_ON: assert property ((started[1] && power_q[1] == `FPT_POWER_FULL)
    [*2] |-> fan_sw_on[1])
    else $error("full power channel not on");
  AST_PWM_WRAP: assert property ((slice_q == 32'(PWM_SLICE_CYC - 1)
    && step_q == LAST_STEP) |=> step_q == 7'h00 && slice_q == 32'h0)
    else $error("PWM period wrong");
  AST_WIN_LEN: assert property (win_last |=> win_q == 32'h0
    && cur_ch_q == $past(cur_ch_q) + 2'd1)
    else $error("window did not end on time");
  AST_ROUND: assert property (!win_last |=> $stable(cur_ch_q))
    else $error("channel changed inside a window");
  AST_FORCE_OWN: assert property (force_vec[1] |-> cur_ch_q == 2'd1)
    else $error("stretch outlived its window");
  AST_BOOT_OFF: assert property (!started[3] |=> !fan_sw_on[3])
    else $error("fan on before its start slot");
  AST_RPM_READ: assert property ((arvalid && arready && rpm_mode_q
    && araddr == (`FPT_SPEED_OFS + 8'h08))
    |=> rdata == $past(32'(edges[2]) * RPM_SCALE >> ppr_q[2]))
    else $error("speed read not in RPM");
endmodule
